// ### gst_pkg.sv
// Package with register map, field positions and reset values of the timer
package gst_pkg;
	// Register bus geometry
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_INTCTL = 8'h0B;
	localparam logic [7:0] IDX_PFLAGS = 8'h0C;
	localparam logic [7:0] IDX_CNTL = 8'h0E;
	localparam logic [7:0] IDX_CNTH = 8'h0F;
	localparam logic [7:0] IDX_TCTL = 8'h10;
	localparam logic [7:0] IDX_CMP2 = 8'h1A;
	localparam logic [7:0] IDX_PEN = 8'h8C;
	localparam logic [1:0] BYTE_LANE0 = 2'h0;
	// Timer control fields
	localparam int TC_ON = 0;
	localparam int TC_CS = 1;
	localparam int TC_SYNC = 2;
	localparam int TC_LPOSC = 3;
	localparam int TC_PS_LO = 4;
	localparam int TC_PS_HI = 5;
	localparam int TC_GE = 6;
	localparam int TC_GINV = 7;
	// Interrupt control, flags, enables, comparator control fields
	localparam int IC_PERIPHERAL_IRQ_ENABLE = 6;
	localparam int IC_GIE = 7;
	localparam int PF_OVF = 0;
	localparam int PE_OVF = 0;
	localparam int CC_GSS = 1;
	// Reset values and implemented bit masks
	localparam logic [7:0] TCTL_RST = 8'h00;
	localparam logic [7:0] INTCTL_RST = 8'h00;
	localparam logic [7:0] INTCTL_MASK = 8'hC0;
	localparam logic [7:0] CMP2_RST = 8'h02;
	localparam logic [7:0] CMP2_MASK = 8'h03;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	// Instruction cycle is the system clock divided by four
	localparam logic [1:0] PHASE_LAST = 2'h3;
	localparam logic [1:0] PHASE_ONE = 2'h1;
	localparam logic [2:0] PSC_RST = 3'h0;
	localparam logic [2:0] PSC_ONE = 3'h1;
	localparam logic [1:0] PHASE_RST = 2'h0;
	// Prescaler terminal counts for divide by 1, 2, 4 and 8
	localparam logic [2:0] PSC_LAST_D1 = 3'h0;
	localparam logic [2:0] PSC_LAST_D2 = 3'h1;
	localparam logic [2:0] PSC_LAST_D4 = 3'h3;
	localparam logic [2:0] PSC_LAST_D8 = 3'h7;
endpackage

// ### gst_psc_if.sv
// Interface between the timer core and its prescale counter
`timescale 1ns/10ps
`default_nettype none
interface gst_psc_if;
	logic tick;
	logic clear;
	logic [1:0] sel;
	logic out;
	logic [2:0] cnt;
	modport ctl (output tick, clear, sel, input out, cnt);
	modport psc (input tick, clear, sel, output out, cnt);
endinterface
`default_nettype wire

// ### gst_prescaler.sv
// Three-bit prescale counter with a two-bit select, dividing by 1, 2, 4 or 8
`timescale 1ns/10ps
`default_nettype none
module gst_prescaler import gst_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	gst_psc_if.psc p
);
	logic [2:0] cnt_q;
	logic [2:0] last;

	// Terminal count: 0, 1, 3 or 7 for the four settings
	// Division ratio select
	always_comb begin
		last = PSC_LAST_D1;
		unique case (p.sel)
			2'b00: last = PSC_LAST_D1;
			2'b01: last = PSC_LAST_D2;
			2'b10: last = PSC_LAST_D4;
			2'b11: last = PSC_LAST_D8;
		endcase
	end

	// Pulse at or past the terminal tick; a clear suppresses it
	// A stale count left by a larger ratio fires at once, never wraps round
	assign p.out = p.tick & ~p.clear & (cnt_q >= last);
	assign p.cnt = cnt_q;

	// Counter; cleared by counter byte writes, never by the gate
	// Clear on byte write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= PSC_RST;
		end else if (p.clear) begin
			cnt_q <= PSC_RST;
		end else if (p.tick) begin
			cnt_q <= (cnt_q >= last) ? PSC_RST : cnt_q + PSC_ONE;
		end
	end

	psc_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		p.clear |=> (cnt_q == PSC_RST))
		else $error("prescaler not cleared after counter write");

	div_eight_a: assert property (@(posedge pclk) disable iff (!presetn)
		(p.out && p.sel == 2'b11) |-> (cnt_q == PSC_LAST_D8))
		else $error("divide by eight pulse at wrong count");

	psc_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!p.tick && !p.clear) |=> $stable(p.cnt))
		else $error("prescaler moved without a tick or clear");
endmodule
`default_nettype wire

// ### gst_timer.sv
// Gated sixteen bit timer with prescaler and APB register slave
`timescale 1ns/10ps
`default_nettype none
// Function
// - Sixteen-bit count runs upward and wraps from all ones to zero.
// - Every wrap sets the overflow flag in peripheral flags bit 0.
// - Interrupt requested only with overflow, peripheral and global enables.
// - Overflow flag stays set until software writes it to zero.
// - Internal source counts once per four system clocks, ignores sync.
// - External source counts rising edges of the external clock pin.
// - External counting needs a falling edge before the first counted rise.
// - Prescale field divides the input by one, two, four or eight.
// - Prescaler is hidden from software and cleared by byte writes.
// - Gate enable ignored when off; when set, counts only gate inactive.
// - Gate source is gate pin or comparator two output, by select bit.
// - Gate invert flips the gate signal for either source.
// - Low-power oscillator enable works only on internal oscillator clock.
// - External clock is synchronised unless the sync disable bit is set.
// - Counter on bit enables counting; off holds the value.
// - Asynchronous counting continues in sleep and may raise wake interrupt.
// - Counter byte reads return a valid value in asynchronous counting.
// - Sleep wake on overflow with on, overflow and peripheral enables.
module gst_timer import gst_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_clock_pin,
	input wire logic lp_osc_clock,
	input wire logic gate_pin,
	input wire logic comparator_two_output,
	input wire logic internal_oscillator_active,
	input wire logic sleep_active,
	output logic irq_request,
	output logic wake_request,
	output logic lp_osc_on
);
	gst_psc_if psc_bus ();

	logic [7:0] tctl_q, intctl_q, cmp2_q;
	logic pen_q, flag_q;
	logic [15:0] count_q;
	logic [1:0] phase_q;
	logic sync1_q, sync2_q, sync3_q, async1_q, async2_q;
	logic armed_q, pready_q, pslverr_q;
	logic [DATA_W-1:0] prdata_q;
	logic irq_q, wake_q, lposc_q;

	logic acc_start, wr_fire;
	logic hit_intctl, hit_pflags, hit_cntl, hit_cnth;
	logic hit_tctl, hit_cmp2, hit_pen, mapped;
	logic [7:0] rd_val;
	logic cnt_wr, lp_active, ext_src, async_mode;
	logic edge_now, edge_prev, ext_rise, ext_fall;
	logic gate_sig, gate_ok, awake, run, instr_tick, src_tick;
	logic inc, wrap, flag_d;

	// Bus phases: answer one cycle into the access phase
	assign acc_start = psel & penable & ~pready_q;
	assign wr_fire = psel & penable & pwrite & pready_q;

	// Address decode on aligned word addresses
	assign hit_intctl = (paddr == {IDX_INTCTL, BYTE_LANE0});
	assign hit_pflags = (paddr == {IDX_PFLAGS, BYTE_LANE0});
	assign hit_cntl = (paddr == {IDX_CNTL, BYTE_LANE0});
	assign hit_cnth = (paddr == {IDX_CNTH, BYTE_LANE0});
	assign hit_tctl = (paddr == {IDX_TCTL, BYTE_LANE0});
	assign hit_cmp2 = (paddr == {IDX_CMP2, BYTE_LANE0});
	assign hit_pen = (paddr == {IDX_PEN, BYTE_LANE0});
	assign mapped = hit_intctl | hit_pflags | hit_cntl | hit_cnth |
		hit_tctl | hit_cmp2 | hit_pen;

	// Read mux; the count is on pclk so reads always see a settled value
	// Valid counter reads
	always_comb begin
		rd_val = 8'h00;
		if (hit_intctl) begin
			rd_val = intctl_q;
		end else if (hit_pflags) begin
			rd_val = {7'h00, flag_q};
		end else if (hit_cntl) begin
			rd_val = count_q[7:0];
		end else if (hit_cnth) begin
			rd_val = count_q[15:8];
		end else if (hit_tctl) begin
			rd_val = tctl_q;
		end else if (hit_cmp2) begin
			rd_val = cmp2_q;
		end else if (hit_pen) begin
			rd_val = {7'h00, pen_q};
		end
	end

	// Bus answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end else begin
			pready_q <= acc_start;
			pslverr_q <= acc_start & ~mapped;
			if (acc_start & ~pwrite) begin
				prdata_q <= {24'h000000, rd_val};
			end
		end
	end

	// Software-written control registers
	// Control register storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tctl_q <= TCTL_RST;
			intctl_q <= INTCTL_RST;
			cmp2_q <= CMP2_RST;
			pen_q <= 1'b0;
		end else if (wr_fire) begin
			if (hit_tctl) begin
				tctl_q <= pwdata[7:0];
			end
			if (hit_intctl) begin
				intctl_q <= pwdata[7:0] & INTCTL_MASK;
			end
			if (hit_cmp2) begin
				cmp2_q <= pwdata[7:0] & CMP2_MASK;
			end
			if (hit_pen) begin
				pen_q <= pwdata[PE_OVF];
			end
		end
	end

	// Low-power oscillator replaces the pin only on the internal oscillator
	// Oscillator enable qualified
	assign lp_active = tctl_q[TC_LPOSC] & internal_oscillator_active;
	assign ext_src = lp_active ? lp_osc_clock : ext_clock_pin;
	assign async_mode = tctl_q[TC_SYNC];

	// Two-stage synchroniser plus edge history, and a raw sample path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
			async1_q <= 1'b0;
			async2_q <= 1'b0;
		end else begin
			sync1_q <= ext_src;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			async1_q <= ext_src;
			async2_q <= async1_q;
		end
	end

	// Edge detection on the chosen path
	// Synchronised or not
	assign edge_now = async_mode ? async1_q : sync2_q;
	assign edge_prev = async_mode ? async2_q : sync3_q;
	assign ext_rise = edge_now & ~edge_prev;
	assign ext_fall = ~edge_now & edge_prev;

	// Arm on the first falling edge after external source selection
	// Falling edge first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed_q <= 1'b0;
		end else if (!tctl_q[TC_CS]) begin
			armed_q <= 1'b0;
		end else if (ext_fall) begin
			armed_q <= 1'b1;
		end
	end

	// Free-running instruction phase divider
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_q <= PHASE_RST;
		end else begin
			phase_q <= phase_q + PHASE_ONE;
		end
	end
	assign instr_tick = (phase_q == PHASE_LAST);

	// Gate source, polarity and enable; high selected signal lets it count
	// Gate source select
	assign gate_sig = (cmp2_q[CC_GSS] ? gate_pin : comparator_two_output) ^
		tctl_q[TC_GINV];
	assign gate_ok = ~tctl_q[TC_GE] | gate_sig;

	// Only asynchronous external counting survives sleep
	// Counting in sleep
	assign awake = ~sleep_active | (tctl_q[TC_CS] & async_mode);
	assign run = tctl_q[TC_ON] & gate_ok & awake;

	// Source tick into the prescaler
	// Internal instruction clock
	assign src_tick = tctl_q[TC_CS] ? (ext_rise & armed_q) : instr_tick;
	assign cnt_wr = wr_fire & (hit_cntl | hit_cnth);
	assign psc_bus.tick = run & src_tick;
	assign psc_bus.clear = cnt_wr;
	assign psc_bus.sel = tctl_q[TC_PS_HI:TC_PS_LO];

	gst_prescaler u_psc (
		.pclk(pclk),
		.presetn(presetn),
		.p(psc_bus.psc)
	);

	assign inc = psc_bus.out;
	assign wrap = inc & (count_q == CNT_MAX);

	// Count register; a byte write wins over an increment
	// Byte load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= CNT_RST;
		end else if (wr_fire & hit_cntl) begin
			count_q[7:0] <= pwdata[7:0];
		end else if (wr_fire & hit_cnth) begin
			count_q[15:8] <= pwdata[7:0];
		end else if (inc) begin
			count_q <= count_q + CNT_ONE;
		end
	end

	// Overflow flag; a wrap in the clearing cycle wins
	// Flag set on wrap
	always_comb begin
		flag_d = flag_q;
		if (wr_fire & hit_pflags) begin
			flag_d = pwdata[PF_OVF];
		end
		if (wrap) begin
			flag_d = 1'b1;
		end
	end

	// Registered requests and oscillator control
	// Interrupt enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 1'b0;
			irq_q <= 1'b0;
			wake_q <= 1'b0;
			lposc_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
			irq_q <= flag_q & pen_q & intctl_q[IC_PERIPHERAL_IRQ_ENABLE] & intctl_q[IC_GIE];
			wake_q <= sleep_active & tctl_q[TC_ON] & flag_q & pen_q &
				intctl_q[IC_PERIPHERAL_IRQ_ENABLE];
			lposc_q <= lp_active;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq_request = irq_q;
	assign wake_request = wake_q;
	assign lp_osc_on = lposc_q;

	sequence instr_gap_s;
		!instr_tick [*3] ##1 instr_tick;
	endsequence

	instr_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
		instr_tick |=> instr_gap_s)
		else $error("instruction tick not every four clocks");

	count_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wrap && !cnt_wr) |=> (count_q == CNT_RST))
		else $error("count did not wrap to zero");

	wrap_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		wrap |=> flag_q)
		else $error("overflow flag not set on wrap");

	flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(flag_q && !(wr_fire && hit_pflags)) |=> flag_q)
		else $error("overflow flag cleared without software");

	irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		##1 irq_request == $past(flag_q & pen_q & intctl_q[IC_PERIPHERAL_IRQ_ENABLE] &
		intctl_q[IC_GIE]))
		else $error("interrupt request not gated by enables");

	off_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!tctl_q[TC_ON] && !cnt_wr) |=> $stable(count_q))
		else $error("count changed while timer off");

	gate_block_a: assert property (@(posedge pclk) disable iff (!presetn)
		(tctl_q[TC_GE] && !gate_sig && !cnt_wr) |=> $stable(count_q))
		else $error("count changed while gate active");

	ext_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
		(tctl_q[TC_CS] && !armed_q) |-> !psc_bus.tick)
		else $error("rising edge counted before falling edge");

	byte_load_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_fire && hit_cntl) |=> (count_q[7:0] == $past(pwdata[7:0])))
		else $error("low count byte not loaded");

	wake_a: assert property (@(posedge pclk) disable iff (!presetn)
		(sleep_active && tctl_q[TC_ON] && flag_q && pen_q &&
		intctl_q[IC_PERIPHERAL_IRQ_ENABLE]) |=> wake_request)
		else $error("no wake request on overflow in sleep");
endmodule
`default_nettype wire

// ### gst_far_side.sv
// Far-side model driving the external clock, low-power clock and gate lines
`timescale 1ns/10ps
`default_nettype none
module gst_far_side (
	input wire logic pclk,
	output logic ext_clock_pin,
	output logic lp_osc_clock,
	output logic gate_pin,
	output logic comparator_two_output
);
	// Idle levels: external line low, low-power line high
	initial begin
		ext_clock_pin = 1'b0;
		lp_osc_clock = 1'b1;
		gate_pin = 1'b0;
		comparator_two_output = 1'b0;
	end
	// One level on the chosen clock line, held four system clocks
	task automatic level(input bit lp, input logic lv);
		@(posedge pclk);
		if (lp) begin
			lp_osc_clock <= lv;
		end else begin
			ext_clock_pin <= lv;
		end
		repeat (3) @(posedge pclk);
	endtask
	// Whole clock periods, rise first; the line stands still afterwards
	task automatic pulses(input bit lp, input int n);
		repeat (n) begin
			level(lp, 1'b1);
			level(lp, 1'b0);
		end
	endtask
	// Gate pin and comparator output levels
	task automatic set_gate(input logic g, input logic c);
		@(posedge pclk);
		gate_pin <= g;
		comparator_two_output <= c;
	endtask
endmodule
`default_nettype wire

// ### gated_sixteen_bit_timer_test.sv
// Self-checking bench for the gated sixteen bit timer
`timescale 1ns/10ps
`default_nettype none
module gated_sixteen_bit_timer_test import gst_pkg::*; ;
	logic pclk, presetn, psel, penable, pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata;
	logic pready, pslverr, irq_request, wake_request, lp_osc_on;
	logic ext_clock_pin, lp_osc_clock, gate_pin, comparator_two_output;
	logic internal_oscillator_active, sleep_active;
	logic [31:0] v;
	logic e;
	logic [7:0] tc;
	int mismatches, checks_done, exp_cnt, k, n, counted;
	// Clock at 50 MHz
	initial pclk = 1'b0;
	always #10 pclk = ~pclk;
	gst_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_clock_pin(ext_clock_pin), .lp_osc_clock(lp_osc_clock),
		.gate_pin(gate_pin), .comparator_two_output(comparator_two_output),
		.internal_oscillator_active(internal_oscillator_active),
		.sleep_active(sleep_active), .irq_request(irq_request),
		.wake_request(wake_request), .lp_osc_on(lp_osc_on));
	gst_far_side P (.pclk(pclk), .ext_clock_pin(ext_clock_pin),
		.lp_osc_clock(lp_osc_clock), .gate_pin(gate_pin),
		.comparator_two_output(comparator_two_output));
	// Verdict and end of run
	task automatic end_of_test;
		if (mismatches == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Single comparison point
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// APB transfer: setup, access until pready, then release
	task automatic apb(input logic wr, input logic [7:0] idx,
		input logic [7:0] wd);
		int t;
		t = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, BYTE_LANE0};
		pwdata <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		v = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (t >= 20) begin
			mismatches++;
			end_of_test;
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		apb(1'b1, idx, wd);
	endtask
	task automatic rdc(input string what, input logic [7:0] idx,
		input logic [31:0] exp);
		apb(1'b0, idx, 8'h00);
		check(what, v, exp);
	endtask
	// Counter byte pair helpers
	task automatic load(input logic [15:0] x);
		wr(IDX_CNTL, x[7:0]);
		wr(IDX_CNTH, x[15:8]);
	endtask
	task automatic rdcnt(input logic [15:0] x);
		rdc("count low", IDX_CNTL, {24'h000000, x[7:0]});
		rdc("count high", IDX_CNTH, {24'h000000, x[15:8]});
	endtask
	// Timer on for exactly len edges between the two control writes
	task automatic run(input logic [7:0] t, input int len);
		wr(IDX_TCTL, t);
		repeat (len - 4) @(posedge pclk);
		wr(IDX_TCTL, t & 8'hFE);
	endtask
	// Main sequence
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		presetn = 1'b0;
		internal_oscillator_active = 1'b0;
		sleep_active = 1'b0;
		mismatches = 0;
		checks_done = 0;
		void'($urandom(60487));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, implemented bits and an unmapped place
		rdc("timer control", IDX_TCTL, {24'h0, TCTL_RST});
		rdc("interrupt control", IDX_INTCTL, {24'h0, INTCTL_RST});
		rdc("comparator control", IDX_CMP2, {24'h0, CMP2_RST});
		rdc("flags", IDX_PFLAGS, 32'h00000000);
		rdc("enables", IDX_PEN, 32'h00000000);
		rdcnt(CNT_RST);
		wr(IDX_INTCTL, 8'hFF);
		rdc("interrupt control bits", IDX_INTCTL, {24'h0, INTCTL_MASK});
		wr(IDX_CMP2, 8'hFF);
		rdc("comparator bits", IDX_CMP2, {24'h0, CMP2_MASK});
		wr(IDX_INTCTL, 8'h00);
		wr(8'h55, 8'hA5);
		check("unmapped write error", {31'h0, e}, 32'h00000001);
		rdc("unmapped read", 8'h55, 32'h00000000);
		check("unmapped read error", {31'h0, e}, 32'h00000001);
		// Prescale ratios with the sync bit set at random
		for (int ps = 0; ps < 4; ps++) begin
			n = 1 << ps;
			k = 1 + $urandom_range(3);
			exp_cnt = $urandom_range(16'hEFFF);
			load(exp_cnt[15:0]);
			rdcnt(exp_cnt[15:0]);
			tc = 8'h01;
			tc[TC_PS_HI:TC_PS_LO] = ps[1:0];
			tc[TC_SYNC] = 1'($urandom_range(1));
			run(tc, 4 * n * k);
			exp_cnt += k;
			rdcnt(exp_cnt[15:0]);
		end
		repeat (40) @(posedge pclk);
		rdcnt(exp_cnt[15:0]);
		// Byte write drops five pending ticks of the divide-by-eight
		run(8'h31, 20);
		wr(IDX_CNTL, exp_cnt[7:0]);
		run(8'h31, 24);
		rdcnt(exp_cnt[15:0]);
		// Gate source, polarity and level, count never reloaded
		for (int i = 0; i < 8; i++) begin
			wr(IDX_CMP2, {6'h00, i[0], 1'b0});
			P.set_gate(i[2] ^ ~i[0], i[2] ^ i[0]);
			run({i[1], 7'h41}, 16);
			exp_cnt += (i[2] ^ i[1]) ? 4 : 0;
			rdcnt(exp_cnt[15:0]);
		end
		run(8'h01, 16);
		exp_cnt += 4;
		rdcnt(exp_cnt[15:0]);
		// count and flag cleared before enabling
		load(16'h0000);
		wr(IDX_PFLAGS, 8'h00);
		wr(IDX_PEN, 8'h01);
		wr(IDX_INTCTL, 8'hC0);
		load(16'hFFFE);
		run(8'h01, 8);
		rdcnt(16'h0000);
		rdc("overflow flag", IDX_PFLAGS, 32'h00000001);
		for (int j = 0; j < 8; j++) begin
			wr(IDX_PEN, {7'h00, j[0]});
			wr(IDX_INTCTL, {j[2:1], 6'h00});
			repeat (2) @(posedge pclk);
			check("irq request", {31'h0, irq_request}, j == 7);
		end
		repeat (50) @(posedge pclk);
		rdc("flag kept", IDX_PFLAGS, 32'h00000001);
		wr(IDX_PFLAGS, 8'h00);
		rdc("flag cleared", IDX_PFLAGS, 32'h00000000);
		// External counting: sync or raw sample, awake or asleep
		wr(IDX_PEN, 8'h01);
		wr(IDX_INTCTL, 8'h40);
		for (int m = 0; m < 4; m++) begin
			k = 2 + $urandom_range(3);
			exp_cnt = 65536 - k;
			load(exp_cnt[15:0]);
			wr(IDX_PFLAGS, 8'h00);
			sleep_active <= m[1];
			wr(IDX_TCTL, {5'h00, m[0], 2'b11});
			P.pulses(1'b0, k + 1);
			repeat (4) @(posedge pclk);
			counted = (m == 2) ? 0 : k;
			check("wake", {31'h0, wake_request}, m == 3);
			check("irq asleep", {31'h0, irq_request}, 32'h0);
			sleep_active <= 1'b0;
			wr(IDX_TCTL, 8'h00);
			exp_cnt += counted;
			rdcnt(exp_cnt[15:0]);
			rdc("ext flag", IDX_PFLAGS, counted == k);
		end
		// Low-power oscillator qualified by the internal oscillator
		for (int q = 0; q < 2; q++) begin
			internal_oscillator_active <= q[0];
			wr(IDX_TCTL, 8'h08);
			repeat (2) @(posedge pclk);
			check("lp osc on", {31'h0, lp_osc_on}, q);
		end
		load(16'h0000);
		wr(IDX_TCTL, 8'h0B);
		P.pulses(1'b1, 4);
		repeat (4) @(posedge pclk);
		wr(IDX_TCTL, 8'h00);
		rdcnt(16'h0003);
		end_of_test;
	end
endmodule
`default_nettype wire
